/* File: common/tedc_map.svh */
/*
 * Register offsets, field positions, masks and reset values of the timer
 * event, interrupt and DMA request block.
 * Assumes a 12-bit APB byte address and 32-bit data.
 */
`ifndef TEDC_MAP_SVH
`define TEDC_MAP_SVH

`define TEDC_OFF_ENABLE 12'h00C
`define TEDC_OFF_STATUS 12'h010
`define TEDC_OFF_GENERATE 12'h014
`define TEDC_OFF_CONFIG 12'h080
`define TEDC_OFF_CAPTURE0 12'h084

`define TEDC_BIT_UPDATE 0
`define TEDC_BIT_CHAN1 1
`define TEDC_BIT_COMMUT 5
`define TEDC_BIT_TRIGGER 6
`define TEDC_BIT_BRAKE 7
`define TEDC_BIT_OVERCAP1 9
`define TEDC_BIT_DMA_BASE 8

`define TEDC_ENABLE_MASK 16'h7FFF
`define TEDC_STATUS_MASK 16'h1EFF
`define TEDC_ENABLE_RESET 16'h0000
`define TEDC_STATUS_RESET 16'h0000
`define TEDC_CONFIG_RESET 15'h0000
`define TEDC_COUNTER_ZERO 16'h0000

`define TEDC_SLAVE_GATED 3'h5

`endif

/* File: common/tedc_pkg.sv */
/*
 * Types of the timer event, interrupt and DMA request block.
 * Assumes nothing beyond the register map header.
 */
package tedc_pkg;

    // Control bits of one complementary channel, moved together on commutation.
    typedef struct packed {
        logic out_en;
        logic comp_out_en;
        logic [2:0] out_mode;
    } tedc_chan_ctrl_t;

    // Block configuration held in the configuration register, high bit first.
    typedef struct packed {
        logic main_output_enable;
        logic trigger_falling;
        logic brake_active_low;
        logic [2:0] slave_mode;
        logic [3:0] chan_is_input;
        logic count_down;
        logic center_aligned;
        logic update_source_restrict;
        logic update_disable;
        logic control_preload_en;
    } tedc_cfg_t;

endpackage : tedc_pkg

/* File: core/tedc_edge_det.sv */
/*
 * Edge detector for a synchronous level input.
 * Assumes the input is already synchronous to pclk.
 */
`timescale 1ns/10ps
module tedc_edge_det (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic rise,
    output logic fall
);
    logic prev_ff;
    logic nxt_prev;

    always_comb begin
        nxt_prev = din;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
        end
    end

    assign rise = din & ~prev_ff;
    assign fall = ~din & prev_ff;
endmodule : tedc_edge_det

/* File: core/tedc_flag_bank.sv */
/*
 * Sticky status flags: hardware sets, software clears by writing zero.
 * Assumes set and clear requests are one-cycle pulses on pclk.
 */
`timescale 1ns/10ps
`include "tedc_map.svh"
module tedc_flag_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] set_req,
    input wire logic [15:0] clr_req,
    output logic [15:0] flags
);
    logic [15:0] flags_ff;
    logic [15:0] nxt_flags;

    // A set in the same cycle as a clear keeps the flag, so no event is lost.
    always_comb begin
        nxt_flags = ((flags_ff & ~clr_req) | set_req) & `TEDC_STATUS_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= `TEDC_STATUS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;
endmodule : tedc_flag_bank

/* File: core/tedc_timer_events.sv */
/*
 * Event, interrupt and DMA request logic of an advanced-control timer,
 * with its APB register slave.
 * Assumes the counter core, slave-mode controller and channel logic are
 * outside and exchange one-cycle pulses and levels synchronous to pclk.
 */
`timescale 1ns/10ps
`include "tedc_map.svh"
module tedc_timer_events (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] counter_value,
    input wire logic [15:0] autoreload,
    input wire logic [3:0] compare_match,
    input wire logic [3:0] capture_event,
    input wire logic rep_wrap,
    input wire logic trig_reinit,
    input wire logic trigger_input_sel,
    input wire logic brake_in,
    input wire tedc_pkg::tedc_chan_ctrl_t [2:0] chan_preload,
    output tedc_pkg::tedc_chan_ctrl_t [2:0] chan_active,
    output logic irq,
    output logic [6:0] dma_req,
    output logic counter_load,
    output logic [15:0] counter_load_value,
    output logic prescaler_clear,
    output logic main_output_enable
);
    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr == off);
    endfunction : hit

    function automatic logic cap_hit(input logic [11:0] addr, input int idx);
        cap_hit = (addr == (`TEDC_OFF_CAPTURE0 + 12'(idx * 4)));
    endfunction : cap_hit

    logic setup_ph;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [3:0] cap_sel;

    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;

    always_comb begin
        cap_sel = 4'h0;
        for (int i = 0; i < 4; i++) begin
            cap_sel[i] = cap_hit(paddr, i);
        end
        mapped = hit(paddr, `TEDC_OFF_ENABLE) | hit(paddr, `TEDC_OFF_STATUS) |
                 hit(paddr, `TEDC_OFF_GENERATE) | hit(paddr, `TEDC_OFF_CONFIG) |
                 (|cap_sel);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable and configuration registers.

    logic [15:0] enable_ff;
    logic [15:0] nxt_enable;
    tedc_pkg::tedc_cfg_t cfg_ff;
    tedc_pkg::tedc_cfg_t nxt_cfg;
    logic brake_gen;
    logic brake_level;

    always_comb begin
        nxt_enable = enable_ff;
        if (wr_acc && hit(paddr, `TEDC_OFF_ENABLE)) begin
            nxt_enable = pwdata[15:0] & `TEDC_ENABLE_MASK;
        end
        nxt_cfg = cfg_ff;
        if (wr_acc && hit(paddr, `TEDC_OFF_CONFIG)) begin
            nxt_cfg = tedc_pkg::tedc_cfg_t'(pwdata[14:0]);
        end
        // Either brake source wins over a software attempt to enable outputs.
        if (brake_gen || brake_level) begin
            nxt_cfg.main_output_enable = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff <= `TEDC_ENABLE_RESET;
            cfg_ff <= tedc_pkg::tedc_cfg_t'(`TEDC_CONFIG_RESET);
        end else begin
            enable_ff <= nxt_enable;
            cfg_ff <= nxt_cfg;
        end
    end

    assign main_output_enable = cfg_ff.main_output_enable;

    ////////////////////////////////////////////////////////////////////////////
    // Software event generation: write-only strobes, no stored bits.

    logic [7:0] gen;
    logic upd_gen;
    logic trig_gen;
    logic com_gen;
    logic [3:0] chan_gen;

    // Zero bits produce nothing, so the self-clearing bits need no storage.
    assign gen = (wr_acc && hit(paddr, `TEDC_OFF_GENERATE)) ? pwdata[7:0] : 8'h00;
    assign upd_gen = gen[`TEDC_BIT_UPDATE];
    assign chan_gen = gen[4:1];
    assign com_gen = gen[`TEDC_BIT_COMMUT];
    assign trig_gen = gen[`TEDC_BIT_TRIGGER];
    assign brake_gen = gen[`TEDC_BIT_BRAKE];

    ////////////////////////////////////////////////////////////////////////////
    // Event sources.

    logic trig_rise;
    logic trig_fall;
    logic trig_edge;
    logic trig_evt;
    logic upd_evt;
    logic com_evt;
    logic [3:0] chan_evt;
    logic [3:0] cap_now;
    logic [3:0] overcap;

    tedc_edge_det u_trig_edge (
        .pclk(pclk),
        .presetn(presetn),
        .din(trigger_input_sel),
        .rise(trig_rise),
        .fall(trig_fall)
    );

    assign brake_level = brake_in ^ cfg_ff.brake_active_low;

    always_comb begin
        if (cfg_ff.slave_mode == `TEDC_SLAVE_GATED) begin
            trig_edge = trig_rise | trig_fall;
        end else begin
            trig_edge = cfg_ff.trigger_falling ? trig_fall : trig_rise;
        end
    end

    assign trig_evt = trig_edge | trig_gen;
    // Repetition wrap needs only updates enabled; reinit sources also need no restriction.
    assign upd_evt = (rep_wrap & ~cfg_ff.update_disable) |
                     ((upd_gen | trig_reinit) & ~cfg_ff.update_disable &
                      ~cfg_ff.update_source_restrict);
    assign com_evt = com_gen & cfg_ff.control_preload_en;

    logic [15:0] flags;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cap_now[i] = cfg_ff.chan_is_input[i] & (capture_event[i] | chan_gen[i]);
            chan_evt[i] = cap_now[i] | (~cfg_ff.chan_is_input[i] &
                          ((compare_match[i] & ~cfg_ff.center_aligned) | chan_gen[i]));
            overcap[i] = cap_now[i] & flags[`TEDC_BIT_CHAN1 + i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags.

    logic [15:0] set_req;
    logic [15:0] clr_req;

    always_comb begin
        set_req = 16'h0000;
        set_req[`TEDC_BIT_UPDATE] = upd_evt;
        set_req[4:1] = chan_evt;
        set_req[`TEDC_BIT_COMMUT] = com_evt;
        set_req[`TEDC_BIT_TRIGGER] = trig_evt;
        set_req[`TEDC_BIT_BRAKE] = brake_level | brake_gen;
        set_req[12:9] = overcap;
        clr_req = 16'h0000;
        if (wr_acc && hit(paddr, `TEDC_OFF_STATUS)) begin
            clr_req = ~pwdata[15:0];
        end
        for (int i = 0; i < 4; i++) begin
            if (rd_acc && cap_sel[i] && cfg_ff.chan_is_input[i]) begin
                clr_req[`TEDC_BIT_CHAN1 + i] = 1'b1;
            end
        end
    end

    tedc_flag_bank u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_req(set_req),
        .clr_req(clr_req),
        .flags(flags)
    );

    assign irq = |(flags[7:0] & enable_ff[7:0]);

    ////////////////////////////////////////////////////////////////////////////
    // Capture registers, DMA pulses, counter reload and commutation transfer.

    logic [15:0] capture_ff [4];
    logic [15:0] nxt_capture [4];
    logic [6:0] dma_ff;
    logic [6:0] nxt_dma;
    logic load_ff;
    logic nxt_load;
    logic [15:0] load_value_ff;
    logic [15:0] nxt_load_value;
    tedc_pkg::tedc_chan_ctrl_t [2:0] active_ff;
    tedc_pkg::tedc_chan_ctrl_t [2:0] nxt_active;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nxt_capture[i] = cap_now[i] ? counter_value : capture_ff[i];
        end
        nxt_dma = enable_ff[14:8] & {trig_evt, com_evt, chan_evt, upd_evt};
        nxt_load = upd_gen;
        nxt_load_value = load_value_ff;
        if (upd_gen) begin
            nxt_load_value = (cfg_ff.count_down && !cfg_ff.center_aligned) ?
                             autoreload : `TEDC_COUNTER_ZERO;
        end
        // Without preload the channel controls track their inputs directly.
        if (!cfg_ff.control_preload_en || com_gen) begin
            nxt_active = chan_preload;
        end else begin
            nxt_active = active_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                capture_ff[i] <= `TEDC_COUNTER_ZERO;
            end
            dma_ff <= 7'h00;
            load_ff <= 1'b0;
            load_value_ff <= `TEDC_COUNTER_ZERO;
            active_ff <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                capture_ff[i] <= nxt_capture[i];
            end
            dma_ff <= nxt_dma;
            load_ff <= nxt_load;
            load_value_ff <= nxt_load_value;
            active_ff <= nxt_active;
        end
    end

    assign dma_req = dma_ff;
    assign counter_load = load_ff;
    assign counter_load_value = load_value_ff;
    assign prescaler_clear = load_ff;
    assign chan_active = active_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Read data, latched in the setup phase so the access phase needs no wait.

    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic err_ff;
    logic nxt_err;

    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_err = err_ff;
        if (setup_ph) begin
            nxt_err = ~mapped;
            nxt_rdata = 32'h0000_0000;
            if (hit(paddr, `TEDC_OFF_ENABLE)) begin
                nxt_rdata = {16'h0000, enable_ff};
            end else if (hit(paddr, `TEDC_OFF_STATUS)) begin
                nxt_rdata = {16'h0000, flags};
            end else if (hit(paddr, `TEDC_OFF_CONFIG)) begin
                nxt_rdata = {17'h00000, cfg_ff};
            end
            for (int i = 0; i < 4; i++) begin
                if (cap_sel[i]) begin
                    nxt_rdata = {16'h0000, capture_ff[i]};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
        end
    end

    assign prdata = rdata_ff;
    assign pready = 1'b1;
    assign pslverr = psel & penable & err_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit(paddr, `TEDC_OFF_STATUS) && !pwdata[6] && !trig_evt) |=> !flags[6])
        else $error("trigger flag not cleared by a zero write");
    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        upd_evt |=> flags[0])
        else $error("update event lost");
    a_overcap_set: assert property (@(posedge pclk) disable iff (!presetn)
        (capture_event[0] && cfg_ff.chan_is_input[0] && flags[1]) |=> flags[9])
        else $error("repeat capture not flagged");
    a_brake_flag: assert property (@(posedge pclk) disable iff (!presetn)
        brake_level |=> (flags[7] && !main_output_enable))
        else $error("brake level did not flag or disable outputs");
    a_trig_gated: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(trigger_input_sel) && cfg_ff.slave_mode == `TEDC_SLAVE_GATED) |=> flags[6])
        else $error("gated falling edge not flagged");
    a_compare_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (compare_match[0] && !cfg_ff.chan_is_input[0] && !cfg_ff.center_aligned) |=> flags[1])
        else $error("compare match not flagged");
    a_capture_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && cap_sel[0] && cfg_ff.chan_is_input[0] && !set_req[1]) |=> !flags[1])
        else $error("capture read did not clear flag");
    a_update_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (rep_wrap && !cfg_ff.update_disable) |=> (flags[0] && dma_req[0] == $past(enable_ff[8])))
        else $error("repetition wrap gave no update");
    a_ug_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (upd_gen && !cfg_ff.count_down) |=> (counter_load && prescaler_clear &&
                                            counter_load_value == 16'h0000))
        else $error("update generate did not reload zero");
    a_irq_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(flags[6]) && enable_ff[6]) |-> irq)
        else $error("enabled trigger flag without interrupt");
    a_gen_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && hit(paddr, `TEDC_OFF_GENERATE)) |=> (prdata == 32'h0000_0000))
        else $error("generate register not read as zero");
endmodule : tedc_timer_events

/* File: dv/tedc_irq_dma_sink.sv */
/*
 * Stand-in for the DMA controller at the far side of the
 * timer event block: it counts every DMA request pulse per source.
 * Assumes dma_req bits are one-cycle pulses synchronous to pclk.
 */
`timescale 1ns/10ps
module tedc_irq_dma_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] dma_req,
    output logic [6:0][7:0] dma_cnt
);
    // A real DMA engine serves one transfer per pulse, so a pulse that lasts
    // two cycles shows up here as two requests.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_cnt <= '0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (dma_req[i] === 1'b1) begin
                    dma_cnt[i] <= dma_cnt[i] + 8'h01;
                end
            end
        end
    end
endmodule : tedc_irq_dma_sink

/* File: dv/tedc_timer_events_bench.sv */
/*
 * Self-checking bench of the timer event, interrupt and DMA request block.
 * Assumes the APB slave answers with pready and the event inputs are
 * sampled on every rising edge of pclk.
 */
`timescale 1ns/10ps
`include "tedc_map.svh"
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
end
module tedc_timer_events_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] counter_value, autoreload, counter_load_value, last_load;
    logic [3:0] compare_match, capture_event;
    logic rep_wrap, trig_reinit, trigger_input_sel, brake_in, irq;
    logic counter_load, prescaler_clear, main_output_enable, last_pc;
    tedc_pkg::tedc_chan_ctrl_t [2:0] chan_preload, chan_active;
    tedc_pkg::tedc_cfg_t cfg;
    logic [6:0] dma_req;
    logic [6:0][7:0] dma_cnt, snap;
    int n_errors = 0;
    int num_checks = 0;
    int n_loads = 0;

    tedc_timer_events u_tedc_timer_events (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .counter_value(counter_value),
        .autoreload(autoreload), .compare_match(compare_match),
        .capture_event(capture_event), .rep_wrap(rep_wrap), .trig_reinit(trig_reinit),
        .trigger_input_sel(trigger_input_sel), .brake_in(brake_in),
        .chan_preload(chan_preload), .chan_active(chan_active), .irq(irq),
        .dma_req(dma_req), .counter_load(counter_load),
        .counter_load_value(counter_load_value), .prescaler_clear(prescaler_clear),
        .main_output_enable(main_output_enable)
    );

    tedc_irq_dma_sink u_tedc_irq_dma_sink (
        .pclk(pclk), .presetn(presetn), .dma_req(dma_req), .dma_cnt(dma_cnt)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Counter reloads are single pulses, so they are caught as they pass.
    always @(posedge pclk) begin
        if (counter_load === 1'b1) begin
            n_loads++;
            last_load = counter_load_value;
            last_pc = prescaler_clear;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n

    task automatic stat(input logic [15:0] e);
        apb(1'b0, `TEDC_OFF_STATUS, 16'h0000);
        `CHK(q, {16'h0000, e})
        apb(1'b1, `TEDC_OFF_STATUS, 16'h0000);
    endtask : stat

    task automatic setcfg();
        apb(1'b1, `TEDC_OFF_CONFIG, {1'b0, cfg});
        wait_n(1);
    endtask : setcfg

    task automatic gen(input logic [15:0] d);
        apb(1'b1, `TEDC_OFF_GENERATE, d);
        wait_n(3);
    endtask : gen

    task automatic pulse(input int s, input logic [3:0] v);
        @(posedge pclk);
        case (s)
            0: compare_match <= v;
            1: capture_event <= v;
            2: rep_wrap <= v[0];
            default: trig_reinit <= v[0];
        endcase
        @(posedge pclk);
        {compare_match, capture_event, rep_wrap, trig_reinit} <= '0;
        wait_n(3);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        apb(1'b0, `TEDC_OFF_ENABLE, 16'h0000);
        `CHK(q, 32'h00000000)
        stat(16'h0000);
        apb(1'b1, `TEDC_OFF_ENABLE, 16'hFFFF);
        apb(1'b0, `TEDC_OFF_ENABLE, 16'h0000);
        `CHK(q, 32'h00007FFF)
        apb(1'b0, 12'h040, 16'h0000);
        `CHK({err, q}, 33'h100000000)
    endtask : test_regs

    task automatic test_compare();
        apb(1'b1, `TEDC_OFF_ENABLE, 16'h0202);
        snap = dma_cnt;
        pulse(0, 4'h1);
        `CHK(irq, 1'b1)
        `CHK(dma_cnt[1], snap[1] + 8'h01)
        apb(1'b1, `TEDC_OFF_STATUS, 16'hFFFF);
        apb(1'b0, `TEDC_OFF_STATUS, 16'h0000);
        `CHK(q, 32'h00000002)
        apb(1'b1, `TEDC_OFF_ENABLE, 16'h0000);
        wait_n(1);
        `CHK(irq, 1'b0)
        snap = dma_cnt;
        pulse(0, 4'h1);
        `CHK(dma_cnt[1], snap[1])
        stat(16'h0002);
        apb(1'b1, `TEDC_OFF_ENABLE, 16'h7FFF);
        cfg.center_aligned = 1'b1;
        setcfg();
        pulse(0, 4'hF);
        stat(16'h0000);
        cfg = '0;
        cfg.chan_is_input = 4'h2;
        setcfg();
        pulse(0, 4'h3);
        stat(16'h0002);
    endtask : test_compare

    task automatic test_capture();
        cfg = '0;
        cfg.chan_is_input = 4'h1;
        setcfg();
        pulse(1, 4'h1);
        pulse(1, 4'h1);
        apb(1'b0, `TEDC_OFF_STATUS, 16'h0000);
        `CHK(q, 32'h00000202)
        apb(1'b0, `TEDC_OFF_CAPTURE0, 16'h0000);
        wait_n(1);
        stat(16'h0200);
    endtask : test_capture

    task automatic test_update();
        int n;
        cfg = '0;
        setcfg();
        snap = dma_cnt;
        n = n_loads;
        gen(16'h0001);
        `CHK(n_loads, n + 1)
        `CHK({last_pc, last_load}, 17'h10000)
        `CHK(dma_cnt[0], snap[0] + 8'h01)
        stat(16'h0001);
        cfg.count_down = 1'b1;
        setcfg();
        gen(16'h0001);
        `CHK(last_load, 16'hABCD)
        stat(16'h0001);
        cfg.update_disable = 1'b1;
        setcfg();
        gen(16'h0001);
        stat(16'h0000);
        pulse(2, 4'h1);
        stat(16'h0000);
        cfg = '0;
        setcfg();
        pulse(2, 4'h1);
        stat(16'h0001);
        pulse(3, 4'h1);
        stat(16'h0001);
        cfg.update_source_restrict = 1'b1;
        setcfg();
        gen(16'h0001);
        stat(16'h0000);
        n = n_loads;
        gen(16'hFF00);
        `CHK(n_loads, n)
        stat(16'h0000);
    endtask : test_update

    task automatic test_trigger();
        cfg = '0;
        setcfg();
        snap = dma_cnt;
        gen(16'h0040);
        `CHK(irq, 1'b1)
        `CHK(dma_cnt[6], snap[6] + 8'h01)
        stat(16'h0040);
        wait_n(4);
        stat(16'h0000);
        trigger_input_sel <= 1'b1;
        wait_n(4);
        stat(16'h0040);
        trigger_input_sel <= 1'b0;
        wait_n(4);
        stat(16'h0000);
        cfg.slave_mode = `TEDC_SLAVE_GATED;
        setcfg();
        trigger_input_sel <= 1'b1;
        wait_n(4);
        stat(16'h0040);
        trigger_input_sel <= 1'b0;
        wait_n(4);
        stat(16'h0040);
        cfg.slave_mode = 3'h0;
        cfg.trigger_falling = 1'b1;
        setcfg();
        trigger_input_sel <= 1'b1;
        wait_n(4);
        stat(16'h0000);
        trigger_input_sel <= 1'b0;
        wait_n(4);
        stat(16'h0040);
    endtask : test_trigger

    task automatic test_brake();
        cfg = '0;
        cfg.main_output_enable = 1'b1;
        setcfg();
        `CHK(main_output_enable, 1'b1)
        gen(16'h0080);
        `CHK({main_output_enable, irq}, 2'b01)
        stat(16'h0080);
        setcfg();
        brake_in <= 1'b1;
        wait_n(4);
        `CHK(main_output_enable, 1'b0)
        brake_in <= 1'b0;
        wait_n(2);
        stat(16'h0080);
        cfg.brake_active_low = 1'b1;
        setcfg();
        wait_n(1);
        `CHK(main_output_enable, 1'b0)
        cfg.brake_active_low = 1'b0;
        setcfg();
        stat(16'h0080);
    endtask : test_brake

    task automatic test_commut();
        cfg = '0;
        cfg.control_preload_en = 1'b1;
        setcfg();
        chan_preload <= 15'h5A6B;
        wait_n(2);
        `CHK(chan_active, 15'h0000)
        snap = dma_cnt;
        gen(16'h0020);
        `CHK(chan_active, 15'h5A6B)
        `CHK(dma_cnt[5], snap[5] + 8'h01)
        stat(16'h0020);
        cfg.control_preload_en = 1'b0;
        setcfg();
        gen(16'h0020);
        stat(16'h0000);
    endtask : test_commut

    task automatic test_chan_gen();
        cfg = '0;
        setcfg();
        snap = dma_cnt;
        gen(16'h001E);
        for (int i = 1; i < 5; i++) begin
            `CHK(dma_cnt[i], snap[i] + 8'h01)
        end
        stat(16'h001E);
        cfg.chan_is_input = 4'h4;
        setcfg();
        gen(16'h0008);
        gen(16'h0008);
        apb(1'b0, `TEDC_OFF_CAPTURE0 + 12'h008, 16'h0000);
        `CHK(q, 32'h00005A5A)
        wait_n(1);
        stat(16'h0800);
    endtask : test_chan_gen

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {compare_match, capture_event, rep_wrap, trig_reinit} = '0;
        {trigger_input_sel, brake_in, chan_preload} = '0;
        counter_value = 16'h5A5A;
        autoreload = 16'hABCD;
        cfg = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_compare();
        test_capture();
        test_update();
        test_trigger();
        test_brake();
        test_commut();
        test_chan_gen();
        wrap_up();
    end

    // The whole sequence takes under a thousand cycles; this leaves ample slack.
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule : tedc_timer_events_bench
